// ### rtl/adc_ctrl_pkg.sv
// Constants of the converter control register and its serial link.
// Assumes every user imports the whole package.
package adc_ctrl_pkg;

    localparam int unsigned  CR_W          = 32;
    localparam int unsigned  NPAIR         = 3;
    localparam int unsigned  TRIM_W        = 10;
    localparam logic [31:0]  CR_RESET      = 32'h000003ff;
    localparam logic [31:0]  CR_RSVD_MASK  = 32'h00081000;

    localparam int unsigned  PAIR_EN_LSB   = 29;
    localparam int unsigned  RANGE_LSB     = 26;
    localparam int unsigned  INT_VREF_BIT  = 25;
    localparam int unsigned  VREF_BUF_BIT  = 24;
    localparam int unsigned  STAGGER_BIT   = 23;
    localparam int unsigned  AUTO_NAP_BIT  = 22;
    localparam int unsigned  DONE_IRQ_BIT  = 21;
    localparam int unsigned  DONE_POL_BIT  = 20;
    localparam int unsigned  VREF_3V_BIT   = 18;
    localparam int unsigned  READBACK_BIT  = 17;
    localparam int unsigned  FULL_UPD_BIT  = 16;
    localparam int unsigned  SLEEP_LSB     = 13;
    localparam int unsigned  CLK_SRC_BIT   = 11;
    localparam int unsigned  CLK_EXP_BIT   = 10;
    localparam int unsigned  TRIM_LSB      = 0;

    localparam logic [5:0]   FRAME_BITS    = 6'h20;

    localparam logic [1:0]   WIDX_FIRST    = 2'h0;
    localparam logic [1:0]   WIDX_SECOND   = 2'h1;
    localparam logic [1:0]   WIDX_THIRD    = 2'h2;
    localparam logic [1:0]   WIDX_FOURTH   = 2'h3;

endpackage

// ### rtl/chain_link.sv
// Serial link end: shifts the control word in and results out on the serial clock.
// Assumes sclk_i falls once with frame_sync_n_i high before each frame.
`timescale 1ns/100ps
module chain_link
(
    // Link clock and system reset
    input  wire logic                sclk_i,
    input  wire logic                rst_n_i,
    // Mode pins, raw
    input  wire logic                serial_mode_i,
    input  wire logic                chain_mode_pin_i,
    // Serial pins
    input  wire logic                frame_sync_n_i,
    input  wire logic                sdi_i,
    input  wire logic                chain_in_a_i,
    input  wire logic                chain_in_b_i,
    input  wire logic                chain_in_c_i,
    output logic                     serial_result_out_a_o,
    output logic                     serial_result_out_b_o,
    output logic                     serial_result_out_c_o,
    // Words from the system domain
    input  wire logic [31:0]         cr_word_i,
    input  wire logic                cr_tog_i,
    input  wire logic [95:0]         res_word_i,
    input  wire logic                res_tog_i,
    // Events to the system domain
    output logic [31:0]              upd_word_o,
    output logic                     upd_tog_o,
    output logic                     frame_tog_o
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [1:0]  ser_sync;
        logic [1:0]  chain_sync;
        logic [2:0]  cr_tsync;
        logic [2:0]  res_tsync;
        logic [31:0] cr_copy;
        logic [95:0] res_copy;
        logic        active;
        logic [5:0]  cnt;
        logic [95:0] shift;
        logic [31:0] rx;
        logic [31:0] upd_word;
        logic        upd_tog;
        logic        frame_tog;
    } link_s;

    link_s       q;
    link_s       d;
    logic [2:0]  chain_in;
    logic        chain_on;

    assign chain_in = {chain_in_c_i, chain_in_b_i, chain_in_a_i};

    always_comb
    begin
        d            = q;
        chain_on     = q.ser_sync[1] & q.chain_sync[1];
        d.rst_sync   = {q.rst_sync[0], rst_n_i};
        d.ser_sync   = {q.ser_sync[0], serial_mode_i};
        d.chain_sync = {q.chain_sync[0], chain_mode_pin_i};
        d.cr_tsync   = {q.cr_tsync[1:0], cr_tog_i};
        d.res_tsync  = {q.res_tsync[1:0], res_tog_i};
        if (q.cr_tsync[2] != q.cr_tsync[1])
        begin
            d.cr_copy = cr_word_i;
        end
        if (q.res_tsync[2] != q.res_tsync[1])
        begin
            d.res_copy = res_word_i;
        end
        if (frame_sync_n_i)
        begin
            d.active = 1'b0;
            d.cnt    = 6'h00;
            for (int ch = 0; ch < NPAIR; ch++)
            begin
                d.shift[ch*32 +: 32] = q.cr_copy[READBACK_BIT] ? q.cr_copy : q.res_copy[ch*32 +: 32];
            end
        end
        else
        begin
            if (!q.active)
            begin
                d.active    = 1'b1;
                d.frame_tog = ~q.frame_tog;
            end
            d.rx = {q.rx[30:0], sdi_i};
            for (int ch = 0; ch < NPAIR; ch++)
            begin
                d.shift[ch*32 +: 32] = {q.shift[ch*32 +: 31], chain_on & chain_in[ch]};
            end
            if (q.cnt != FRAME_BITS)
            begin
                d.cnt = q.cnt + 6'h01;
            end
            if (q.cnt == FRAME_BITS - 6'h01)
            begin
                d.upd_word = {q.rx[30:0], sdi_i};
                d.upd_tog  = ~q.upd_tog;
            end
        end
        if (!q.rst_sync[1])
        begin
            d.cr_copy  = CR_RESET;
            d.res_copy = '0;
            d.active   = 1'b0;
            d.cnt      = 6'h00;
            d.shift    = '0;
            d.rx        = '0;
            d.upd_word  = '0;
            d.upd_tog   = 1'b0;
            d.frame_tog = 1'b0;
        end
    end

    always_ff @(negedge sclk_i)
    begin
        q <= d;
    end

    assign serial_result_out_a_o = q.shift[31];
    assign serial_result_out_b_o = q.shift[63];
    assign serial_result_out_c_o = q.shift[95];
    assign upd_word_o            = q.upd_word;
    assign upd_tog_o             = q.upd_tog;
    assign frame_tog_o           = q.frame_tog;

endmodule

// ### rtl/adc_ctrl_top.sv
// Control register of a six-channel converter with parallel and serial update.
// Assumes the analog core delivers results and conversion status on sys_clk_i.
`timescale 1ns/100ps
module adc_ctrl_top
(
    // System clock and reset
    input  wire logic                            sys_clk_i,
    input  wire logic                            rst_n_i,
    // Mode pins
    input  wire logic                            serial_mode_i,
    input  wire logic                            soft_config_i,
    input  wire logic                            byte_mode_i,
    input  wire logic                            chain_mode_pin_i,
    // Parallel port
    input  wire logic                            cs_n_i,
    input  wire logic                            wr_n_i,
    input  wire logic [15:0]                     db_i,
    // Serial port on its own clock
    input  wire logic                            sclk_i,
    input  wire logic                            frame_sync_n_i,
    input  wire logic                            sdi_i,
    input  wire logic                            chain_in_a_i,
    input  wire logic                            chain_in_b_i,
    input  wire logic                            chain_in_c_i,
    output logic                                 serial_result_out_a_o,
    output logic                                 serial_result_out_b_o,
    output logic                                 serial_result_out_c_o,
    // Analog core status and results
    input  wire logic                            conv_busy_i,
    input  wire logic                            conv_done_i,
    input  wire logic                            res_stb_i,
    input  wire logic [31:0]                     res_a_i,
    input  wire logic [31:0]                     res_b_i,
    input  wire logic [31:0]                     res_c_i,
    // Conversion-done pin
    output logic                                 done_pin_o,
    // Settings to the analog core
    output logic [adc_ctrl_pkg::NPAIR-1:0]       pair_enable_o,
    output logic [adc_ctrl_pkg::NPAIR-1:0]       range_2x_o,
    output logic [adc_ctrl_pkg::NPAIR-1:0]       pair_sleep_o,
    output logic                                 int_vref_on_o,
    output logic                                 vref_buffer_off_o,
    output logic                                 staggered_start_o,
    output logic                                 auto_nap_o,
    output logic                                 vref_3v_o,
    output logic                                 conv_clock_source_o,
    output logic                                 conv_clock_export_o,
    output logic [adc_ctrl_pkg::TRIM_W-1:0]      vref_trim_code_o,
    // Stored register for observation
    output logic [adc_ctrl_pkg::CR_W-1:0]        converter_control_o
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        logic [1:0]        ser_sync;
        logic [1:0]        sw_sync;
        logic [1:0]        byte_sync;
        logic [1:0]        wr_n_sync;
        logic [1:0]        cs_n_sync;
        logic [1:0][15:0]  db_sync;
        logic              wr_n_prev;
        logic              cs_n_prev;
        logic [2:0]        upd_tsync;
        logic [2:0]        frame_tsync;
        logic [31:0]       cr;
        logic [15:0]       pend;
        logic [1:0]        widx;
        logic              cr_tog;
        logic [95:0]       res;
        logic              res_tog;
        logic              int_flag;
        logic              done_pin;
        logic [2:0]        pair_en;
        logic [2:0]        range_2x;
        logic [2:0]        pair_sleep;
        logic              int_vref_on;
        logic              vref_buffer_off;
        logic              staggered_start;
        logic              auto_nap;
        logic              vref_3v;
        logic              clk_src;
        logic              clk_exp;
        logic [9:0]        trim;
    } top_s;

    top_s          q;
    top_s          d;
    logic [31:0]   upd_word;
    logic          upd_tog;
    logic          frame_tog;
    logic          sw_mode;
    logic          ser_mode;
    logic          wr_rise;
    logic          cs_fall;
    logic          upd_evt;
    logic          frame_evt;
    logic [31:0]   new_cr;
    logic [15:0]   db;

    chain_link u_link
    (
        .sclk_i                (sclk_i),
        .rst_n_i               (rst_n_i),
        .serial_mode_i         (serial_mode_i),
        .chain_mode_pin_i      (chain_mode_pin_i),
        .frame_sync_n_i        (frame_sync_n_i),
        .sdi_i                 (sdi_i),
        .chain_in_a_i          (chain_in_a_i),
        .chain_in_b_i          (chain_in_b_i),
        .chain_in_c_i          (chain_in_c_i),
        .serial_result_out_a_o (serial_result_out_a_o),
        .serial_result_out_b_o (serial_result_out_b_o),
        .serial_result_out_c_o (serial_result_out_c_o),
        .cr_word_i             (q.cr),
        .cr_tog_i              (q.cr_tog),
        .res_word_i            (q.res),
        .res_tog_i             (q.res_tog),
        .upd_word_o            (upd_word),
        .upd_tog_o             (upd_tog),
        .frame_tog_o           (frame_tog)
    );

    always_comb
    begin
        d           = q;
        sw_mode     = q.sw_sync[1];
        ser_mode    = q.ser_sync[1];
        db          = q.db_sync[1];
        wr_rise     = q.wr_n_sync[1] & ~q.wr_n_prev;
        cs_fall     = q.cs_n_prev & ~q.cs_n_sync[1];
        upd_evt     = q.upd_tsync[2] ^ q.upd_tsync[1];
        frame_evt   = q.frame_tsync[2] ^ q.frame_tsync[1];
        new_cr      = q.cr;

        // Pin and toggle synchronisers.
        d.ser_sync    = {q.ser_sync[0], serial_mode_i};
        d.sw_sync     = {q.sw_sync[0], soft_config_i};
        d.byte_sync   = {q.byte_sync[0], byte_mode_i};
        d.wr_n_sync   = {q.wr_n_sync[0], wr_n_i};
        d.cs_n_sync   = {q.cs_n_sync[0], cs_n_i};
        d.db_sync     = {q.db_sync[0], db_i};
        d.wr_n_prev   = q.wr_n_sync[1];
        d.cs_n_prev   = q.cs_n_sync[1];
        d.upd_tsync   = {q.upd_tsync[1:0], upd_tog};
        d.frame_tsync = {q.frame_tsync[1:0], frame_tog};

        // Parallel writes are counted within one chip select.
        if (q.cs_n_sync[1])
        begin
            d.widx = WIDX_FIRST;
        end
        if (!ser_mode && sw_mode && wr_rise && !q.cs_n_sync[1])
        begin
            case (q.widx)
                WIDX_FIRST:
                begin
                    new_cr[31:24] = db[15:8];
                    d.pend[7:0]   = db[7:0];
                    d.widx        = WIDX_SECOND;
                end
                WIDX_SECOND:
                begin
                    if (q.byte_sync[1])
                    begin
                        d.pend[15:8] = db[15:8];
                        d.widx       = WIDX_THIRD;
                    end
                    else
                    begin
                        new_cr[23:0] = {q.pend[7:0], db};
                        d.widx       = WIDX_FIRST;
                    end
                end
                WIDX_THIRD:
                begin
                    d.pend[7:0] = db[15:8];
                    d.widx      = WIDX_FOURTH;
                end
                WIDX_FOURTH:
                begin
                    new_cr[23:0] = {q.pend, db[15:8]};
                    d.widx       = WIDX_FIRST;
                end
                default:
                begin
                    d.widx = WIDX_FIRST;
                end
            endcase
        end

        // Serial update arrives after the 32nd falling clock edge.
        if (ser_mode && sw_mode && upd_evt)
        begin
            new_cr[31:24] = upd_word[31:24];
            if (upd_word[FULL_UPD_BIT])
            begin
                new_cr[23:0] = upd_word[23:0];
            end
        end
        new_cr = new_cr & ~CR_RSVD_MASK;
        if (new_cr != q.cr)
        begin
            d.cr     = new_cr;
            d.cr_tog = ~q.cr_tog;
        end

        // Results are held for the serial side.
        if (res_stb_i)
        begin
            d.res     = {res_c_i, res_b_i, res_a_i};
            d.res_tog = ~q.res_tog;
        end

        // Interrupt is cleared by the next access; a new event wins.
        if (ser_mode ? frame_evt : cs_fall)
        begin
            d.int_flag = 1'b0;
        end
        if (conv_done_i)
        begin
            d.int_flag = 1'b1;
        end
        if (q.cr[DONE_IRQ_BIT])
        begin
            d.done_pin = q.cr[DONE_POL_BIT] ? q.int_flag : ~q.int_flag;
        end
        else
        begin
            d.done_pin = q.cr[DONE_POL_BIT] ? ~conv_busy_i : conv_busy_i;
        end

        // Settings ignored while pin-configured read as their defaults.
        d.pair_en         = sw_mode ? q.cr[PAIR_EN_LSB +: NPAIR] : 3'h0;
        d.range_2x        = sw_mode ? q.cr[RANGE_LSB +: NPAIR] : 3'h0;
        d.int_vref_on     = sw_mode & q.cr[INT_VREF_BIT];
        d.vref_buffer_off = sw_mode & q.cr[VREF_BUF_BIT];
        d.staggered_start = sw_mode & q.cr[STAGGER_BIT];
        d.clk_src         = sw_mode & q.cr[CLK_SRC_BIT];
        d.clk_exp         = sw_mode & q.cr[CLK_EXP_BIT];
        d.auto_nap        = q.cr[AUTO_NAP_BIT];
        d.vref_3v         = q.cr[VREF_3V_BIT];
        d.pair_sleep      = q.cr[SLEEP_LSB +: NPAIR];
        d.trim            = q.cr[TRIM_LSB +: TRIM_W];

        if (!rst_n_i)
        begin
            d.cr              = CR_RESET;
            d.pend            = 16'h0000;
            d.widx            = WIDX_FIRST;
            d.cr_tog          = 1'b0;
            d.res             = '0;
            d.res_tog         = 1'b0;
            d.int_flag        = 1'b0;
            d.done_pin        = 1'b0;
            d.wr_n_prev       = 1'b1;
            d.cs_n_prev       = 1'b1;
            d.upd_tsync       = 3'h0;
            d.frame_tsync     = 3'h0;
            d.pair_en         = 3'h0;
            d.range_2x        = 3'h0;
            d.pair_sleep      = 3'h0;
            d.int_vref_on     = 1'b0;
            d.vref_buffer_off = 1'b0;
            d.staggered_start = 1'b0;
            d.auto_nap        = 1'b0;
            d.vref_3v         = 1'b0;
            d.clk_src         = 1'b0;
            d.clk_exp         = 1'b0;
            d.trim            = CR_RESET[TRIM_LSB +: TRIM_W];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        q <= d;
    end

    assign done_pin_o          = q.done_pin;
    assign pair_enable_o       = q.pair_en;
    assign range_2x_o          = q.range_2x;
    assign pair_sleep_o        = q.pair_sleep;
    assign int_vref_on_o       = q.int_vref_on;
    assign vref_buffer_off_o   = q.vref_buffer_off;
    assign staggered_start_o   = q.staggered_start;
    assign auto_nap_o          = q.auto_nap;
    assign vref_3v_o           = q.vref_3v;
    assign conv_clock_source_o = q.clk_src;
    assign conv_clock_export_o = q.clk_exp;
    assign vref_trim_code_o    = q.trim;
    assign converter_control_o = q.cr;

endmodule

// ### bench/adc_ctrl_monitor.sv
// Concurrent checks on the converter control block ports.
// Assumes it is bound to adc_ctrl_top and sees only its ports.
`timescale 1ns/100ps
module adc_ctrl_monitor
(
    // Clock, reset and mode
    input wire logic                              sys_clk_i,
    input wire logic                              rst_n_i,
    input wire logic                              soft_config_i,
    // Core status
    input wire logic                              conv_busy_i,
    input wire logic                              conv_done_i,
    // Observed outputs
    input wire logic                              done_pin_o,
    input wire logic [adc_ctrl_pkg::NPAIR-1:0]    pair_sleep_o,
    input wire logic                              auto_nap_o,
    input wire logic                              vref_3v_o,
    input wire logic [adc_ctrl_pkg::TRIM_W-1:0]   vref_trim_code_o,
    input wire logic [adc_ctrl_pkg::CR_W-1:0]     converter_control_o
);
    import adc_ctrl_pkg::*;
    logic [31:0] cc_q1;
    logic [31:0] cc_q2;
    logic [3:0]  soft_lo_q;
    logic        calm;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    always_ff @(posedge sys_clk_i)
    begin
        cc_q1     <= converter_control_o;
        cc_q2     <= cc_q1;
        soft_lo_q <= (!rst_n_i || soft_config_i) ? 4'h0 : soft_lo_q + {3'h0, soft_lo_q != 4'hf};
    end
    assign calm = (converter_control_o == cc_q1) && (cc_q1 == cc_q2);
    reset_value_a: assert property (disable iff (1'b0) !rst_n_i |=> converter_control_o == CR_RESET)
        else $error("control word not at reset value");
    reserved_zero_a: assert property ((converter_control_o & CR_RSVD_MASK) == 32'h0)
        else $error("reserved control bit set");
    busy_pin_a: assert property (calm && !converter_control_o[DONE_IRQ_BIT] |=>
        done_pin_o == ($past(conv_busy_i) ^ $past(converter_control_o[DONE_POL_BIT])))
        else $error("done pin does not follow busy");
    irq_set_a: assert property (calm && converter_control_o[DONE_IRQ_BIT] && conv_done_i ##1 calm |=>
        done_pin_o == $past(converter_control_o[DONE_POL_BIT], 2))
        else $error("interrupt not raised");
    trim_map_a: assert property (calm |-> vref_trim_code_o == converter_control_o[9:0])
        else $error("trim code mismatch");
    nap_map_a: assert property (calm |=> auto_nap_o == $past(converter_control_o[AUTO_NAP_BIT]))
        else $error("auto nap mismatch");
    vref_map_a: assert property (calm |-> vref_3v_o == converter_control_o[VREF_3V_BIT])
        else $error("reference voltage select mismatch");
    sleep_map_a: assert property (calm |-> pair_sleep_o == converter_control_o[15:13])
        else $error("pair sleep mismatch");
    sw_only_a: assert property (soft_lo_q > 4'h7 |-> $stable(converter_control_o))
        else $error("control word changed in pin mode");
endmodule

// ### bench/serial_host.sv
// Host serial model: sends the control word and captures the result outputs.
// Assumes the converter samples and shifts on the falling serial clock edge.
`timescale 1ns/100ps
module serial_host
(
    // Serial pins toward the converter
    output logic             sclk_o,
    output logic             frame_sync_n_o,
    output logic             sdi_o,
    output logic [2:0]       chain_o,
    // Result pins from the converter
    input  wire logic [2:0]  sdo_i
);
    initial
    begin
        sclk_o         = 1'b1;
        frame_sync_n_o = 1'b1;
        sdi_o          = 1'b0;
        chain_o        = 3'h0;
    end
    // Clock pulses with the frame released reload the output shifters.
    task automatic idle(input int n);
        repeat (n)
        begin
            #32 sclk_o = 1'b0;
            #32 sclk_o = 1'b1;
        end
    endtask
    // The word is sent twice; only the first 32 bits commit, since the bit count holds at 32 for the rest of the frame.
    task automatic frame(input logic [31:0] word, input logic [2:0][31:0] up, output logic [2:0][63:0] got);
        idle(6);
        for (int k = 0; k < 64; k++)
        begin
            frame_sync_n_o = 1'b0;
            sdi_o = word[31 - k % 32];
            for (int i = 0; i < 3; i++)
                chain_o[i] = (k < 32) ? up[i][31 - k] : ~chain_o[i];
            for (int i = 0; i < 3; i++)
                got[i][63 - k] = sdo_i[i];
            #32 sclk_o = 1'b0;
            #32 sclk_o = 1'b1;
        end
        frame_sync_n_o = 1'b1;
        sdi_o = ~sdi_o;
        chain_o = ~chain_o;
    endtask
endmodule

// ### bench/adc_ctrl_top_tb.sv
// Self-checking bench for the converter control block.
// Assumes the serial host model and the bound monitor.
`timescale 1ns/100ps
module adc_ctrl_top_tb;
    import adc_ctrl_pkg::*;
    localparam logic [31:0]       W_A   = 32'hf6c5_0d55;
    localparam logic [31:0]       W_B   = 32'h0931_e2aa;
    localparam logic [31:0]       OUT_M = 32'hffc4_efff;
    localparam logic [31:0]       PIN_M = 32'h007f_f3ff;
    localparam logic [1:0][31:0]  WORDS = {W_B, W_A};
    localparam logic [2:0][31:0]  RES   = {32'h0f1e_2d3c, 32'h9abc_def0, 32'h1234_5678};
    localparam logic [2:0][31:0]  UP    = {32'hc0c0_0003, 32'hb0b0_0002, 32'ha0a0_0001};
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, serial_mode_i = 1'b0, soft_config_i = 1'b1, chain_mode_pin_i = 1'b0;
    logic cs_n_i = 1'b1, wr_n_i = 1'b1, conv_busy_i = 1'b0, conv_done_i = 1'b0, res_stb_i = 1'b0, byte_mode_i = 1'b0;
    logic [15:0] db_i = 16'h0;
    logic [31:0] res_a_i = 32'h0, res_b_i = 32'h0, res_c_i = 32'h0;
    logic sclk_i, frame_sync_n_i, sdi_i, done_pin_o, serial_result_out_a_o, serial_result_out_b_o, serial_result_out_c_o;
    logic [2:0] chain_in, pair_enable_o, range_2x_o, pair_sleep_o;
    logic int_vref_on_o, vref_buffer_off_o, staggered_start_o, auto_nap_o, vref_3v_o;
    logic conv_clock_source_o, conv_clock_export_o;
    logic [9:0] vref_trim_code_o;
    logic [31:0] converter_control_o, obs;
    logic [2:0][63:0] got;
    int mismatches = 0, num_checks = 0, cycles = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    assign obs = {pair_enable_o, range_2x_o, int_vref_on_o, vref_buffer_off_o, staggered_start_o, auto_nap_o,
                  3'h0, vref_3v_o, 2'h0, pair_sleep_o, 1'b0, conv_clock_source_o, conv_clock_export_o, vref_trim_code_o};
    adc_ctrl_top u_adc_ctrl_top
    (
        .sys_clk_i, .rst_n_i, .serial_mode_i, .soft_config_i, .byte_mode_i, .chain_mode_pin_i,
        .cs_n_i, .wr_n_i, .db_i, .sclk_i, .frame_sync_n_i, .sdi_i, .chain_in_a_i(chain_in[0]),
        .chain_in_b_i(chain_in[1]), .chain_in_c_i(chain_in[2]), .serial_result_out_a_o, .serial_result_out_b_o,
        .serial_result_out_c_o, .conv_busy_i, .conv_done_i, .res_stb_i, .res_a_i, .res_b_i, .res_c_i, .done_pin_o,
        .pair_enable_o, .range_2x_o, .pair_sleep_o, .int_vref_on_o, .vref_buffer_off_o, .staggered_start_o,
        .auto_nap_o, .vref_3v_o, .conv_clock_source_o, .conv_clock_export_o, .vref_trim_code_o, .converter_control_o
    );
    serial_host u_serial_host
    (
        .sclk_o(sclk_i), .frame_sync_n_o(frame_sync_n_i), .sdi_o(sdi_i), .chain_o(chain_in),
        .sdo_i({serial_result_out_c_o, serial_result_out_b_o, serial_result_out_a_o})
    );
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic pwr(input logic [31:0] w);
        cs_n_i <= 1'b0;
        for (int h = byte_mode_i ? 3 : 1; h >= 0; h--)
        begin
            db_i <= byte_mode_i ? {w[8*h +: 8], 8'h00} : w[16*h +: 16];
            tick(2);
            wr_n_i <= 1'b0;
            tick(4);
            wr_n_i <= 1'b1;
            tick(4);
        end
        cs_n_i <= 1'b1;
        tick(6);
    endtask
    task automatic sframe(input logic [31:0] w, input logic [2:0][31:0] top, input logic [2:0][31:0] low,
                          input logic [31:0] exp);
        #1;
        u_serial_host.frame(w, UP, got);
        tick(16);
        for (int i = 0; i < 3; i++)
        begin
            chk("serial word", got[i][63:32], top[i]);
            chk("chain word", got[i][31:0], low[i]);
        end
        chk("control", converter_control_o, exp);
    endtask
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
    end
    initial
    begin
        u_serial_host.idle(4);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        tick(4);
        chk("control", converter_control_o, CR_RESET);
        chk("settings", obs, CR_RESET & OUT_M);
        $display("test reset done");
        for (int j = 0; j < 2; j++)
        begin
            pwr(WORDS[j]);
            chk("control", converter_control_o, WORDS[j]);
            chk("settings", obs, WORDS[j] & OUT_M);
        end
        $display("test parallel done");
        conv_done_i <= 1'b1;
        tick(1);
        conv_done_i <= 1'b0;
        tick(2);
        chk("done pin", {31'h0, done_pin_o}, 32'h1);
        cs_n_i <= 1'b0;
        tick(8);
        chk("done pin", {31'h0, done_pin_o}, 32'h0);
        cs_n_i <= 1'b1;
        byte_mode_i <= 1'b1;
        tick(4);
        pwr(W_A);
        chk("control", converter_control_o, W_A);
        byte_mode_i <= 1'b0;
        conv_busy_i <= 1'b1;
        tick(3);
        chk("done pin", {31'h0, done_pin_o}, 32'h1);
        conv_busy_i <= 1'b0;
        tick(3);
        chk("done pin", {31'h0, done_pin_o}, 32'h0);
        $display("test done pin done");
        soft_config_i <= 1'b0;
        tick(12);
        chk("settings", obs, W_A & PIN_M & OUT_M);
        pwr(W_B);
        chk("control", converter_control_o, W_A);
        soft_config_i <= 1'b1;
        $display("test pin mode done");
        serial_mode_i <= 1'b1;
        chain_mode_pin_i <= 1'b1;
        res_a_i <= RES[0];
        res_b_i <= RES[1];
        res_c_i <= RES[2];
        res_stb_i <= 1'b1;
        tick(1);
        res_stb_i <= 1'b0;
        tick(4);
        sframe(W_B, RES, UP, W_B);
        chain_mode_pin_i <= 1'b0;
        tick(1);
        sframe(32'h1600_0000, RES, '0, 32'h1631_e2aa);
        sframe(W_A | 32'h0002_0000 | CR_RSVD_MASK, RES, '0, W_A | 32'h0002_0000);
        sframe(32'h0, {3{W_A | 32'h0002_0000}}, '0, 32'h00c7_0d55);
        $display("test serial done");
        results();
    end
endmodule
bind adc_ctrl_top adc_ctrl_monitor u_adc_ctrl_monitor
(
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .soft_config_i(soft_config_i), .conv_busy_i(conv_busy_i),
    .conv_done_i(conv_done_i), .done_pin_o(done_pin_o), .pair_sleep_o(pair_sleep_o), .auto_nap_o(auto_nap_o),
    .vref_3v_o(vref_3v_o), .vref_trim_code_o(vref_trim_code_o), .converter_control_o(converter_control_o)
);
